// File: include/cswd_pkg.sv
// constants, register map and state codes of the can wake detector
// assumes a 125 mhz hclk and a single ahb-lite slave select
package cswd_pkg;
	// clock rate
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned CLK_KHZ = 125000;
	// wake-up pattern phase minimum times and pattern timeout
	localparam int unsigned WAKE_DOM_NS = 1000;
	localparam int unsigned WAKE_REC_NS = 1000;
	localparam int unsigned WAKE_TO_US = 1000;
	localparam logic [11:0] DOM_CYC = 12'((WAKE_DOM_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] REC_CYC = 12'((WAKE_REC_NS * CLK_MHZ + 999) / 1000);
	// bit times per arbitration rate, in hclk cycles
	localparam logic [11:0] CYC_50K = 12'(CLK_KHZ / 50);
	localparam logic [11:0] CYC_100K = 12'(CLK_KHZ / 100);
	localparam logic [11:0] CYC_125K = 12'(CLK_KHZ / 125);
	localparam logic [11:0] CYC_250K = 12'(CLK_KHZ / 250);
	localparam logic [11:0] CYC_500K = 12'(CLK_KHZ / 500);
	localparam logic [11:0] CYC_667K = 12'(CLK_KHZ / 667);
	localparam logic [11:0] CYC_1000K = 12'(CLK_KHZ / 1000);
	// frame layout
	// header bits after start of frame: id, rtr, ide, r0, dlc / id, srr, ide, id, rtr, r1, r0, dlc
	localparam logic [6:0] HDR_BASE = 7'h12;
	localparam logic [6:0] HDR_EXT = 7'h26;
	localparam logic [6:0] CRC_LEN = 7'h0f;
	localparam int unsigned IDE_POS = 5;
	localparam int unsigned RTR_POS = 6;
	localparam logic [2:0] STUFF_LEN = 3'h5;
	localparam logic [2:0] IDLE_BITS = 3'h7;
	localparam logic [14:0] CRC_POLY = 15'h4599;
	// register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_FCTL = 8'h08;
	localparam logic [7:0] A_ID = 8'h0c;
	localparam logic [7:0] A_IDM = 8'h10;
	localparam logic [7:0] A_DML = 8'h14;
	localparam logic [7:0] A_DMH = 8'h18;
	// status bit positions
	localparam int unsigned ST_PAT = 3;
	localparam int unsigned ST_FRM = 4;
	// reset values and ahb word transfer size
	localparam logic [31:0] DMASK_RST = 32'hffffffff;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// transceiver operating modes
	typedef enum logic [2:0] {
		cswd_off = 3'h0,
		cswd_offline = 3'h1,
		cswd_bias = 3'h2,
		cswd_listen = 3'h3,
		cswd_active = 3'h4
	} cswd_mode_e;
	// bus bias source
	typedef enum logic [1:0] {
		bias_hiz = 2'h0,
		bias_gnd = 2'h1,
		bias_vbat = 2'h2,
		bias_vcc = 2'h3
	} cswd_bias_e;
	// wake-up pattern detector
	typedef enum logic [1:0] {
		w_dom1 = 2'h0,
		w_rec1 = 2'h1,
		w_dom2 = 2'h2,
		w_rec2 = 2'h3
	} cswd_wup_e;
	// frame decoder
	typedef enum logic [2:0] {
		f_idle = 3'h0,
		f_sof = 3'h1,
		f_hdr = 3'h2,
		f_data = 3'h3,
		f_crc = 3'h4,
		f_del = 3'h5
	} cswd_frm_e;
endpackage : cswd_pkg

// File: rtl/cswd_top.sv
// can bus wake-up pattern and selective wake frame detector
// assumes a registered ahb-lite master, one slave, single word transfers
`timescale 1ns/1ps
module cswd_top #(
	parameter int unsigned WAKE_TO_CYC = cswd_pkg::WAKE_TO_US * cswd_pkg::CLK_MHZ
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// bus side pins, low is dominant
	input wire logic can_rxd,
	input wire logic can_txd,
	input wire logic tx_inhibit_n,
	// same-clock inputs
	input wire logic main_off,
	input wire logic pn_error_status,
	// transceiver control
	output logic tx_drive_dom,
	output logic tx_on,
	output logic rx_on,
	output logic [1:0] bias_sel,
	output logic [2:0] can_mode,
	output logic wake_event
);
	// pin synchronisers
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic rx_q;
	wire rx_s = sync2[0];
	wire txd_s = sync2[1];
	wire inh_s = sync2[2];
	wire fedge = rx_q & ~rx_s;

	// registers
	logic [2:0] mode_req;
	logic req_pend;
	logic low_power_listen_sel;
	logic vcc_sel;
	logic can_wake_enable;
	logic pat_sel;
	logic swe;
	logic cfg_ok;
	logic [3:0] cfg_dlc;
	logic ide_sel;
	logic dme;
	logic [2:0] rate_sel;
	logic [28:0] cfg_id;
	logic [28:0] cfg_msk;
	logic [63:0] dmask;
	logic pat_flag;
	logic frm_flag;
	logic last_ok;
	wire req_applied;
	cswd_pkg::cswd_mode_e mode;
	cswd_pkg::cswd_mode_e next_mode;

	// ahb data phase
	logic dp_wr;
	logic [7:0] dp_a;
	wire ahb_go = hsel & htrans[1] & hready;
	wire wr_ctrl = dp_wr & (dp_a == cswd_pkg::A_CTRL);
	wire wr_stat = dp_wr & (dp_a == cswd_pkg::A_STAT);
	wire wr_fctl = dp_wr & (dp_a == cswd_pkg::A_FCTL);
	wire wr_id = dp_wr & (dp_a == cswd_pkg::A_ID);
	wire wr_idm = dp_wr & (dp_a == cswd_pkg::A_IDM);
	wire wr_dml = dp_wr & (dp_a == cswd_pkg::A_DML);
	wire wr_dmh = dp_wr & (dp_a == cswd_pkg::A_DMH);
	wire wr_filt = wr_fctl | wr_id | wr_idm | wr_dml | wr_dmh;
	wire [31:0] ctrl_rd = {23'h0, cfg_ok, swe, pat_sel, can_wake_enable, vcc_sel, low_power_listen_sel, mode_req};
	wire [31:0] stat_rd = {26'h0, last_ok, frm_flag, pat_flag, mode};
	wire [31:0] fctl_rd = {23'h0, rate_sel, dme, ide_sel, cfg_dlc};
	wire [7:0] ra = haddr[7:0];
	wire [31:0] rmux = (ra == cswd_pkg::A_CTRL) ? ctrl_rd :
		(ra == cswd_pkg::A_STAT) ? stat_rd :
		(ra == cswd_pkg::A_FCTL) ? fctl_rd :
		(ra == cswd_pkg::A_ID) ? {3'h0, cfg_id} :
		(ra == cswd_pkg::A_IDM) ? {3'h0, cfg_msk} :
		(ra == cswd_pkg::A_DML) ? dmask[31:0] :
		(ra == cswd_pkg::A_DMH) ? dmask[63:32] : 32'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
			rx_q <= 1'b1;
		end else begin
			sync1 <= {tx_inhibit_n, can_txd, can_rxd};
			sync2 <= sync1;
			rx_q <= rx_s;
		end
	end

	// zero wait state; read data is fetched in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr <= 1'b0;
			dp_a <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			dp_wr <= ahb_go & hwrite & (hsize == cswd_pkg::HSIZE_WORD);
			dp_a <= haddr[7:0];
			if (ahb_go & ~hwrite)
				hrdata <= rmux;
		end
	end

	// control register and mode request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_req <= 3'h0;
			req_pend <= 1'b0;
			{swe, pat_sel, can_wake_enable, vcc_sel, low_power_listen_sel} <= 5'h00;
		end else begin
			if (wr_ctrl) begin
				mode_req <= hwdata[2:0];
				{swe, pat_sel, can_wake_enable, vcc_sel, low_power_listen_sel} <= hwdata[7:3];
			end
			if (wr_ctrl)
				req_pend <= 1'b1;
			else if (req_applied)
				req_pend <= 1'b0;
		end
	end

	// any filter change forces software to revalidate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cfg_ok <= 1'b0;
		else if (wr_filt)
			cfg_ok <= 1'b0;
		else if (wr_ctrl)
			cfg_ok <= hwdata[8];
	end

	// filter configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{rate_sel, dme, ide_sel, cfg_dlc} <= 9'h000;
			cfg_id <= 29'h0;
			cfg_msk <= 29'h0;
			dmask <= {cswd_pkg::DMASK_RST, cswd_pkg::DMASK_RST};
		end else begin
			if (wr_fctl)
				{rate_sel, dme, ide_sel, cfg_dlc} <= hwdata[8:0];
			if (wr_id)
				cfg_id <= hwdata[28:0];
			if (wr_idm)
				cfg_msk <= hwdata[28:0];
			if (wr_dml)
				dmask[31:0] <= hwdata;
			if (wr_dmh)
				dmask[63:32] <= hwdata;
		end
	end

	// wake-up pattern detector
	cswd_pkg::cswd_wup_e ws;
	logic [11:0] dom_run;
	logic [11:0] rec_run;
	logic [31:0] wt;
	wire dom_long = dom_run == cswd_pkg::DOM_CYC;
	wire rec_long = rec_run == cswd_pkg::REC_CYC;
	wire wup_armed = (mode == cswd_pkg::cswd_offline) | (mode == cswd_pkg::cswd_bias);
	wire wup_to = (ws != cswd_pkg::w_dom1) & (wt == WAKE_TO_CYC - 1);
	wire wup_hit = wup_armed & ~wup_to &
		(((ws == cswd_pkg::w_dom2) & dom_long & ~pat_sel) |
		((ws == cswd_pkg::w_rec2) & rec_long));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dom_run <= 12'h0;
			rec_run <= 12'h0;
		end else if (!rx_s) begin
			rec_run <= 12'h0;
			if (!dom_long)
				dom_run <= dom_run + 12'h1;
		end else begin
			dom_run <= 12'h0;
			if (!rec_long)
				rec_run <= rec_run + 12'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ws <= cswd_pkg::w_dom1;
			wt <= 32'h0;
		end else if (!wup_armed || wup_hit || wup_to) begin
			ws <= cswd_pkg::w_dom1;
			wt <= 32'h0;
		end else begin
			if (ws != cswd_pkg::w_dom1)
				wt <= wt + 32'h1;
			case (ws)
				cswd_pkg::w_dom1: begin
					if (dom_long)
						ws <= cswd_pkg::w_rec1;
				end
				cswd_pkg::w_rec1: begin
					if (rec_long)
						ws <= cswd_pkg::w_dom2;
				end
				cswd_pkg::w_dom2: begin
					if (dom_long)
						ws <= cswd_pkg::w_rec2;
				end
				default: ;
			endcase
		end
	end

	// bit timing, resynchronised on every recessive to dominant edge
	wire [11:0] bit_cyc = (rate_sel == 3'h0) ? cswd_pkg::CYC_50K :
		(rate_sel == 3'h1) ? cswd_pkg::CYC_100K :
		(rate_sel == 3'h2) ? cswd_pkg::CYC_125K :
		(rate_sel == 3'h3) ? cswd_pkg::CYC_250K :
		(rate_sel == 3'h5) ? cswd_pkg::CYC_667K :
		(rate_sel == 3'h6) ? cswd_pkg::CYC_1000K : cswd_pkg::CYC_500K;
	logic [11:0] bcnt;
	wire samp = ~fedge & (bcnt == {1'b0, bit_cyc[11:1]});

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			bcnt <= 12'h0;
		else if (fedge || bcnt >= bit_cyc - 12'h1)
			bcnt <= 12'h0;
		else
			bcnt <= bcnt + 12'h1;
	end

	// frame decoder
	cswd_pkg::cswd_frm_e fs;
	logic [2:0] ic;
	logic [2:0] same;
	logic last;
	logic [14:0] crc;
	logic [38:0] hdr;
	logic [63:0] data;
	logic [6:0] n;
	logic [6:0] f_dbits;
	logic [28:0] f_id;
	logic f_ide;
	logic f_rtr;
	logic [3:0] f_dlc;
	wire stuff_bit = same == cswd_pkg::STUFF_LEN;
	wire [14:0] crc_nx = {crc[13:0], 1'b0} ^ ((rx_s ^ crc[14]) ? cswd_pkg::CRC_POLY : 15'h0);
	wire [38:0] hdr_nx = {hdr[37:0], rx_s};
	wire [6:0] n_nx = n + 7'h1;
	wire nx_ide = hdr_nx[cswd_pkg::IDE_POS];
	wire hdr_end = ((n_nx == cswd_pkg::HDR_BASE) & ~nx_ide) | (n_nx == cswd_pkg::HDR_EXT);
	wire [3:0] nx_dlc = hdr_nx[3:0];
	wire [3:0] nx_bytes = hdr_nx[cswd_pkg::RTR_POS] ? 4'h0 : (nx_dlc > 4'h8) ? 4'h8 : nx_dlc;
	// a stuff bit may follow the last crc bit, so destuffing runs up to the delimiter
	wire in_body = (fs == cswd_pkg::f_hdr) | (fs == cswd_pkg::f_data) |
		(fs == cswd_pkg::f_crc) | (fs == cswd_pkg::f_del);
	wire frame_done = samp & (fs == cswd_pkg::f_del) & ~stuff_bit & rx_s &
		(crc == 15'h0);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fs <= cswd_pkg::f_idle;
			ic <= 3'h0;
			same <= 3'h0;
			last <= 1'b0;
			crc <= 15'h0;
			hdr <= 39'h0;
			data <= 64'h0;
			n <= 7'h0;
			f_dbits <= 7'h0;
			f_id <= 29'h0;
			f_ide <= 1'b0;
			f_rtr <= 1'b0;
			f_dlc <= 4'h0;
		end else if (fs == cswd_pkg::f_idle) begin
			if (fedge && ic == cswd_pkg::IDLE_BITS)
				fs <= cswd_pkg::f_sof;
			else if (samp)
				ic <= rx_s ? ((ic == cswd_pkg::IDLE_BITS) ? ic : ic + 3'h1) : 3'h0;
		end else if (samp) begin
			ic <= 3'h0;
			if (fs == cswd_pkg::f_sof) begin
				fs <= rx_s ? cswd_pkg::f_idle : cswd_pkg::f_hdr;
				last <= 1'b0;
				same <= 3'h1;
				crc <= 15'h0;
				data <= 64'h0;
				n <= 7'h0;
			end else if (fs == cswd_pkg::f_del && !stuff_bit) begin
				fs <= cswd_pkg::f_idle;
			end else if (in_body && stuff_bit) begin
				// a sixth equal bit is a stuff error, drop the frame
				if (rx_s == last)
					fs <= cswd_pkg::f_idle;
				last <= rx_s;
				same <= 3'h1;
			end else if (in_body) begin
				same <= (rx_s == last) ? same + 3'h1 : 3'h1;
				last <= rx_s;
				crc <= crc_nx;
				n <= n_nx;
				if (fs == cswd_pkg::f_hdr) begin
					hdr <= hdr_nx;
					if (hdr_end) begin
						n <= 7'h0;
						f_ide <= (n_nx == cswd_pkg::HDR_EXT);
						f_rtr <= hdr_nx[cswd_pkg::RTR_POS];
						f_dlc <= nx_dlc;
						f_dbits <= {nx_bytes, 3'h0};
						f_id <= (n_nx == cswd_pkg::HDR_EXT) ? {hdr_nx[37:27], hdr_nx[24:7]} :
							{18'h0, hdr_nx[17:7]};
						fs <= (nx_bytes == 4'h0) ? cswd_pkg::f_crc : cswd_pkg::f_data;
					end
				end else if (fs == cswd_pkg::f_data) begin
					// first byte ends up highest, last byte lands under the lowest mask byte
					data <= {data[62:0], rx_s};
					if (n_nx == f_dbits) begin
						n <= 7'h0;
						fs <= cswd_pkg::f_crc;
					end
				end else if (n_nx == cswd_pkg::CRC_LEN) begin
					fs <= cswd_pkg::f_del;
				end
			end else begin
				fs <= cswd_pkg::f_idle;
			end
		end
	end

	// frame filter
	wire [28:0] id_cmp = f_ide ? 29'h1fffffff : 29'h000007ff;
	wire id_ok = (((f_id ^ cfg_id) & ~cfg_msk & id_cmp) == 29'h0) & (f_ide == ide_sel);
	wire data_ok = (cfg_dlc == 4'h0) | (|(data & dmask));
	wire dlc_ok = ~f_rtr & (f_dlc == cfg_dlc);
	wire frm_match = id_ok & (~dme | (dlc_ok & data_ok));
	wire biased = (mode == cswd_pkg::cswd_bias) | (mode == cswd_pkg::cswd_listen) |
		(mode == cswd_pkg::cswd_active);
	wire frm_wake = frame_done & frm_match & biased & can_wake_enable & cfg_ok & swe &
		~pn_error_status;
	wire pat_wake = wup_hit & can_wake_enable & (~swe | ~cfg_ok);

	// mode machine
	wire req_legal = mode_req <= 3'h4;
	assign req_applied = ~main_off & ~((mode == cswd_pkg::cswd_offline) & wup_hit);

	always_comb begin
		next_mode = mode;
		if (main_off)
			next_mode = cswd_pkg::cswd_off;
		else if (mode == cswd_pkg::cswd_offline && wup_hit)
			next_mode = cswd_pkg::cswd_bias;
		else if (req_pend && req_legal)
			next_mode = cswd_pkg::cswd_mode_e'(mode_req);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			mode <= cswd_pkg::cswd_off;
		else
			mode <= next_mode;
	end

	// transceiver controls
	wire nx_tx_on = (mode == cswd_pkg::cswd_active) |
		((mode == cswd_pkg::cswd_listen) & ~low_power_listen_sel);
	wire nx_dom = (mode == cswd_pkg::cswd_active) & ~inh_s & ~txd_s;
	wire [1:0] listen_bias = (low_power_listen_sel & ~vcc_sel) ? cswd_pkg::bias_vbat : cswd_pkg::bias_vcc;
	wire [1:0] lp_bias = vcc_sel ? cswd_pkg::bias_vcc : cswd_pkg::bias_vbat;
	wire [1:0] nx_bias = (mode == cswd_pkg::cswd_off) ? cswd_pkg::bias_hiz :
		(mode == cswd_pkg::cswd_offline) ? cswd_pkg::bias_gnd :
		(mode == cswd_pkg::cswd_bias) ? lp_bias :
		(mode == cswd_pkg::cswd_listen) ? listen_bias : cswd_pkg::bias_vcc;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_on <= 1'b0;
			tx_drive_dom <= 1'b0;
			rx_on <= 1'b0;
			bias_sel <= cswd_pkg::bias_hiz;
			wake_event <= 1'b0;
		end else begin
			tx_on <= nx_tx_on;
			tx_drive_dom <= nx_dom;
			rx_on <= (mode == cswd_pkg::cswd_listen) | (mode == cswd_pkg::cswd_active);
			bias_sel <= nx_bias;
			wake_event <= pat_wake | frm_wake;
		end
	end

	// sticky wake flags, a new event beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pat_flag <= 1'b0;
			frm_flag <= 1'b0;
			last_ok <= 1'b0;
		end else begin
			pat_flag <= pat_wake | (pat_flag & ~(wr_stat & hwdata[cswd_pkg::ST_PAT]));
			frm_flag <= frm_wake | (frm_flag & ~(wr_stat & hwdata[cswd_pkg::ST_FRM]));
			if (samp && fs == cswd_pkg::f_del && !stuff_bit)
				last_ok <= frame_done;
		end
	end

	assign can_mode = mode;
endmodule : cswd_top

// File: test/cswd_checker.sv
// assertions on the mode, bias and wake outputs of the can wake detector
// bound into cswd_top; one hclk domain, async active-low reset
`timescale 1ns/1ps
module cswd_checker #(
	parameter int unsigned WAKE_TO_CYC = 2000
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// pin and same-clock input
	input wire logic tx_inhibit_n,
	input wire logic main_off,
	// transceiver control
	input wire logic tx_drive_dom,
	input wire logic tx_on,
	input wire logic rx_on,
	input wire logic [1:0] bias_sel,
	input wire logic [2:0] can_mode,
	input wire logic wake_event
);
	logic [2:0] prev_mode;
	logic [2:0] sm;
	// outputs trail the mode by one edge, so judge only a mode held two edges
	assign sm = (can_mode == prev_mode) ? can_mode : 3'h7;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) prev_mode <= 3'h0;
		else prev_mode <= can_mode;
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	off_prio_a: assert property (main_off |=> can_mode == cswd_pkg::cswd_off)
		else $error("mode kept after off condition");
	off_state_a: assert property (sm == cswd_pkg::cswd_off |->
		bias_sel == cswd_pkg::bias_hiz && !tx_on && !rx_on) else $error("off outputs wrong");
	offline_gnd_a: assert property (sm == cswd_pkg::cswd_offline |->
		bias_sel == cswd_pkg::bias_gnd) else $error("offline bias wrong");
	low_tx_off_a: assert property (sm inside {cswd_pkg::cswd_offline, cswd_pkg::cswd_bias} |->
		!tx_on && !rx_on) else $error("low power front end on");
	listen_rx_a: assert property (sm == cswd_pkg::cswd_listen |->
		rx_on && !tx_drive_dom && bias_sel[1]) else $error("listen outputs wrong");
	active_on_a: assert property (sm == cswd_pkg::cswd_active |->
		tx_on && rx_on && bias_sel == cswd_pkg::bias_vcc) else $error("active outputs wrong");
	inhibit_rec_a: assert property (tx_inhibit_n [*4] |-> !tx_drive_dom)
		else $error("driving while inhibited");
	tx_off_a: assert property (!tx_on |-> !tx_drive_dom)
		else $error("driving with transmitter off");
	wake_mode_a: assert property (wake_event |-> $past(can_mode) != cswd_pkg::cswd_off)
		else $error("wake in off mode");
	wake_pulse_a: assert property (wake_event |=> !wake_event)
		else $error("wake longer than one cycle");
endmodule : cswd_checker
bind cswd_top cswd_checker #(.WAKE_TO_CYC(WAKE_TO_CYC)) u_checker (.hclk(hclk),
	.hresetn(hresetn), .tx_inhibit_n(tx_inhibit_n), .main_off(main_off),
	.tx_drive_dom(tx_drive_dom), .tx_on(tx_on), .rx_on(rx_on), .bias_sel(bias_sel),
	.can_mode(can_mode), .wake_event(wake_event));

// File: test/cswd_node.sv
// bus node model sending wake-up patterns and classical frames
// caller enters each task just after a rising hclk edge; idle bus is recessive
`timescale 1ns/1ps
module cswd_node (
	// clock
	input wire logic hclk,
	// bus level, low is dominant
	output logic can_rxd
);
	initial can_rxd = 1'b1;
	task automatic drv(input logic v, input int n);
		can_rxd <= v;
		repeat (n) @(posedge hclk);
	endtask : drv
	// no ack is given, nobody else is on this bus
	task automatic frame(input logic [28:0] id, input logic ext, input logic rtr,
		input logic [3:0] dlc, input logic [15:0] d, input int bt);
		logic q[$];
		logic [14:0] crc;
		logic nx;
		logic last;
		int run;
		crc = 15'h0;
		run = 0;
		last = 1'b1;
		q.push_back(1'b0);
		for (int i = 10; i >= 0; i--) q.push_back(ext ? id[18 + i] : id[i]);
		if (ext) begin
			q.push_back(1'b1);
			q.push_back(1'b1);
			for (int i = 17; i >= 0; i--) q.push_back(id[i]);
		end
		q.push_back(rtr);
		q.push_back(1'b0);
		q.push_back(1'b0);
		for (int i = 3; i >= 0; i--) q.push_back(dlc[i]);
		if (!rtr) for (int i = int'(dlc) * 8 - 1; i >= 0; i--) q.push_back(d[i]);
		foreach (q[k]) begin
			nx = q[k] ^ crc[14];
			crc = {crc[13:0], 1'b0};
			if (nx) crc = crc ^ cswd_pkg::CRC_POLY;
		end
		for (int i = 14; i >= 0; i--) q.push_back(crc[i]);
		drv(1'b1, 7 * bt);
		// stuffing done on the fly, through the last crc bit
		foreach (q[k]) begin
			drv(q[k], bt);
			run = (q[k] == last) ? run + 1 : 1;
			last = q[k];
			if (run == 5) begin
				drv(~last, bt);
				last = ~last;
				run = 1;
			end
		end
		drv(1'b1, 2 * bt);
	endtask : frame
endmodule : cswd_node

// File: test/tb.sv
// self-checking bench for the can wake detector
// one hclk; registers over ahb-lite, frames from cswd_node at 1000 kbit/s, wake-up patterns timed in hclk cycles
`timescale 1ns/1ps
module tb;
	localparam int BT = int'(cswd_pkg::CYC_1000K);
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic can_rxd;
	logic can_txd = 1'b1;
	logic tx_inhibit_n = 1'b1;
	logic main_off = 1'b0;
	logic pn_error_status = 1'b0;
	logic tx_drive_dom;
	logic tx_on;
	logic rx_on;
	logic wake_event;
	logic [1:0] bias_sel;
	logic [2:0] can_mode;
	int err_count = 0;
	int n_compared = 0;
	int wake_cnt = 0;
	int cyc = 0;
	always #4 hclk = ~hclk;
	// short pattern timeout keeps the run brief
	cswd_top #(.WAKE_TO_CYC(2000)) i_cswd_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .can_rxd,
		.can_txd, .tx_inhibit_n, .main_off, .pn_error_status, .tx_drive_dom, .tx_on, .rx_on,
		.bias_sel, .can_mode, .wake_event);
	cswd_node u_node (.hclk(hclk), .can_rxd(can_rxd));
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (wake_event === 1'b1) wake_cnt <= wake_cnt + 1;
		if (cyc == 106000) begin
			err_count++;
			$display("FAIL timeout expected done seen hang");
			end_sim;
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hsize <= cswd_pkg::HSIZE_WORD;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic t_regs;
		logic [31:0] r;
		bus(1'b0, cswd_pkg::A_DML, 32'h0, r);
		chk("dml", r, cswd_pkg::DMASK_RST);
		bus(1'b0, cswd_pkg::A_DMH, 32'h0, r);
		chk("dmh", r, cswd_pkg::DMASK_RST);
		bus(1'b0, 8'h1c, 32'h0, r);
		chk("unmapped", r, 32'h0);
		wr(cswd_pkg::A_CTRL, 32'h100);
		bus(1'b0, cswd_pkg::A_CTRL, 32'h0, r);
		chk("cfg valid set", r[8], 1'h1);
		wr(cswd_pkg::A_IDM, 32'h0);
		bus(1'b0, cswd_pkg::A_CTRL, 32'h0, r);
		chk("cfg valid cleared", r[8], 1'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic md(input logic [31:0] c, input logic [1:0] b, input logic t, input logic r);
		wr(cswd_pkg::A_CTRL, c);
		repeat (4) @(posedge hclk);
		chk("bias_sel", bias_sel, b);
		chk("tx_on", tx_on, t);
		chk("rx_on", rx_on, r);
	endtask : md
	task automatic t_modes;
		md(32'h000, cswd_pkg::bias_hiz, 1'h0, 1'h0);
		md(32'h001, cswd_pkg::bias_gnd, 1'h0, 1'h0);
		md(32'h002, cswd_pkg::bias_vbat, 1'h0, 1'h0);
		md(32'h012, cswd_pkg::bias_vcc, 1'h0, 1'h0);
		md(32'h003, cswd_pkg::bias_vcc, 1'h1, 1'h1);
		md(32'h00b, cswd_pkg::bias_vbat, 1'h0, 1'h1);
		md(32'h004, cswd_pkg::bias_vcc, 1'h1, 1'h1);
		can_txd <= 1'b0;
		tx_inhibit_n <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("tx_drive_dom", tx_drive_dom, 1'h1);
		tx_inhibit_n <= 1'b1;
		repeat (5) @(posedge hclk);
		chk("tx_drive_dom", tx_drive_dom, 1'h0);
		can_txd <= 1'b1;
		main_off <= 1'b1;
		wr(cswd_pkg::A_CTRL, 32'h002);
		repeat (3) @(posedge hclk);
		chk("can_mode", can_mode, cswd_pkg::cswd_off);
		main_off <= 1'b0;
		repeat (3) @(posedge hclk);
		chk("can_mode", can_mode, cswd_pkg::cswd_bias);
		$display("test modes done");
	endtask : t_modes
	// passing through off restarts the pattern detector
	task automatic go(input logic [31:0] c, output int n);
		wr(cswd_pkg::A_CTRL, 32'h0);
		wr(cswd_pkg::A_CTRL, c);
		n = wake_cnt;
	endtask : go
	task automatic pat(input int d1, input int r1, input int d2, input int r2);
		u_node.drv(1'b0, d1);
		u_node.drv(1'b1, r1);
		u_node.drv(1'b0, d2);
		u_node.drv(1'b1, r2);
	endtask : pat
	task automatic t_wup;
		int n;
		go(32'h001, n);
		pat(130, 130, 130, 20);
		chk("can_mode", can_mode, cswd_pkg::cswd_bias);
		chk("wake", wake_cnt - n, 32'h0);
		go(32'h021, n);
		u_node.drv(1'b0, 130);
		u_node.drv(1'b1, 30);
		pat(30, 130, 130, 20);
		chk("wake", wake_cnt - n, 32'h1);
		go(32'h021, n);
		pat(130, 2100, 130, 20);
		chk("wake", wake_cnt - n, 32'h0);
		go(32'h061, n);
		pat(130, 130, 130, 20);
		chk("wake", wake_cnt - n, 32'h0);
		u_node.drv(1'b1, 150);
		chk("wake", wake_cnt - n, 32'h1);
		go(32'h1a1, n);
		pat(130, 130, 130, 20);
		chk("wake", wake_cnt - n, 32'h0);
		$display("test pattern done");
	endtask : t_wup
	task automatic fc(input logic [8:0] fctl, input logic [31:0] dml, input logic [31:0] idm,
		input logic [31:0] fid, input logic ext, input logic rtr, input logic [3:0] dlc,
		input logic [15:0] d, input logic exp);
		int n;
		wr(cswd_pkg::A_FCTL, {23'h0, fctl});
		wr(cswd_pkg::A_ID, ext ? fid : 32'h123);
		wr(cswd_pkg::A_IDM, idm);
		wr(cswd_pkg::A_DML, dml);
		wr(cswd_pkg::A_CTRL, 32'h1a2);
		n = wake_cnt;
		u_node.frame(fid[28:0], ext, rtr, dlc, d, BT);
		chk("frame wake", wake_cnt - n, {31'h0, exp});
	endtask : fc
	task automatic t_frames;
		fc(9'h180, 32'hffffffff, 32'h0, 32'h123, 1'h0, 1'h0, 4'h1, 16'h0, 1'h1);
		fc(9'h180, 32'hffffffff, 32'hf, 32'h12c, 1'h0, 1'h0, 4'h1, 16'h0, 1'h1);
		fc(9'h180, 32'hffffffff, 32'hf, 32'h133, 1'h0, 1'h0, 4'h1, 16'h0, 1'h0);
		fc(9'h1a1, 32'hffffffff, 32'h0, 32'h123, 1'h0, 1'h0, 4'h1, 16'h1, 1'h1);
		fc(9'h1a1, 32'hffffffff, 32'h0, 32'h123, 1'h0, 1'h0, 4'h1, 16'h0, 1'h0);
		fc(9'h1a1, 32'hffffffff, 32'h0, 32'h123, 1'h0, 1'h0, 4'h2, 16'h101, 1'h0);
		fc(9'h1a1, 32'hffffffff, 32'h0, 32'h123, 1'h0, 1'h1, 4'h1, 16'h1, 1'h0);
		fc(9'h1a2, 32'hff00, 32'h0, 32'h123, 1'h0, 1'h0, 4'h2, 16'h100, 1'h1);
		fc(9'h1a2, 32'hff, 32'h0, 32'h123, 1'h0, 1'h0, 4'h2, 16'h100, 1'h0);
		fc(9'h1a1, 32'h0, 32'h0, 32'h123, 1'h0, 1'h0, 4'h1, 16'hff, 1'h0);
		fc(9'h1a0, 32'hffffffff, 32'h0, 32'h123, 1'h0, 1'h0, 4'h0, 16'h0, 1'h1);
		fc(9'h190, 32'hffffffff, 32'h0, 32'h12345678, 1'h1, 1'h0, 4'h1, 16'h0, 1'h1);
		pn_error_status <= 1'b1;
		fc(9'h180, 32'hffffffff, 32'h0, 32'h123, 1'h0, 1'h0, 4'h1, 16'h0, 1'h0);
		pn_error_status <= 1'b0;
		$display("test frames done");
	endtask : t_frames
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_modes;
		t_wup;
		t_frames;
		end_sim;
	end
endmodule : tb
